/* design/xpvrt_top.sv */
// Panel readout timing, video port and register slave
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module xpvrt_top
  import xpvrt_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic binningSelectLow,
  input wire logic binningSelectHigh,
  input wire logic grabberTriggerIn,
  input wire logic coaxTriggerIn,
  input wire logic triggerSourceSelect,
  input wire logic [WORD_W-1:0] adcWord,
  output xpvrt_video_s video,
  output xpvrt_video_s videoN,
  output logic scanActive,
  output logic [2:0] scanGroup,
  output logic [7:0] scanChan,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================================
  // Pin synchronisers
  xpvrt_pins_s pinsRaw;
  xpvrt_pins_s pins;
  logic [4:0] pinsSync;

  assign pinsRaw = '{binningSelectLow, binningSelectHigh, grabberTriggerIn,
                     coaxTriggerIn, triggerSourceSelect};

  xpvrt_sync #(.W(5)) uSync (
    .clk(clk),
    .nrst(nrst),
    .asyncIn(pinsRaw),
    .syncOut(pinsSync)
  );
  assign pins = pinsSync;

  // ==========================================================================
  // Register file and bus state
  logic [1:0] ctrl_q, ctrl_d;
  logic [15:0] tDelay_q, tDelay_d;
  logic awGot_q, awGot_d;
  logic [AXI_AW-1:0] awAddr_q, awAddr_d;
  logic wGot_q, wGot_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic awReady_q, awReady_d;
  logic wReady_q, wReady_d;
  logic bValid_q, bValid_d;
  logic [1:0] bResp_q, bResp_d;
  logic arReady_q, arReady_d;
  logic rValid_q, rValid_d;
  logic [31:0] rData_q, rData_d;
  logic [1:0] rResp_q, rResp_d;
  logic [31:0] statusWord;

  // ==========================================================================
  // Timing state
  xpvrt_state_e state_q, state_d;
  xpvrt_bin_e bin_q, bin_d;
  logic [1:0] pdiv_q, pdiv_d;
  logic [10:0] pixCnt_q, pixCnt_d;
  logic [10:0] lineCnt_q, lineCnt_d;
  logic [15:0] delayCnt_q, delayCnt_d;
  logic [15:0] frameCnt_q, frameCnt_d;
  logic trigPrev_q, trigPrev_d;
  xpvrt_video_s video_q, video_d;
  xpvrt_video_s videoN_q, videoN_d;
  logic scanActive_q, scanActive_d;
  logic [2:0] scanGroup_q, scanGroup_d;
  logic [7:0] scanChan_q, scanChan_d;
  logic tick;
  logic trigLevel;
  logic trigRise;
  logic extMode;
  xpvrt_geom_s geomQ, geomD;
  logic [10:0] pixLast, lineLast;
  logic [10:0] actStart, effStart, gapStart, col, colRaw;
  logic inLine, inEff;

  // ==========================================================================
  // AXI4-Lite slave
  always_comb begin
    statusWord = '0;
    statusWord[0] = state_q == ST_SCAN;
    statusWord[1] = state_q == ST_WAIT;
    statusWord[2] = state_q == ST_DELAY;
    statusWord[4:3] = bin_q;
    statusWord[5] = extMode;
    statusWord[31:16] = frameCnt_q;
  end

  always_comb begin
    ctrl_d = ctrl_q;
    tDelay_d = tDelay_q;
    awGot_d = awGot_q;
    awAddr_d = awAddr_q;
    wGot_d = wGot_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    rValid_d = rValid_q;
    rData_d = rData_q;
    rResp_d = rResp_q;
    if (s_axi_awvalid && awReady_q) begin
      awGot_d = 1'b1;
      awAddr_d = s_axi_awaddr & ADDR_WORD_MASK;
    end
    if (s_axi_wvalid && wReady_q) begin
      wGot_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (awGot_q && wGot_q && !bValid_q) begin
      awGot_d = 1'b0;
      wGot_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = RESP_OKAY;
      unique case (awAddr_q)
        ADDR_CTRL: begin
          if (wStrb_q[0]) begin
            ctrl_d = wData_q[1:0];
          end
        end
        ADDR_TDELAY: begin
          if (wStrb_q[0]) begin
            tDelay_d[7:0] = wData_q[7:0];
          end
          if (wStrb_q[1]) begin
            tDelay_d[15:8] = wData_q[15:8];
          end
        end
        ADDR_STATUS: bResp_d = RESP_OKAY;
        default: bResp_d = RESP_SLVERR;
      endcase
    end
    if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
    if (s_axi_arvalid && arReady_q) begin
      rValid_d = 1'b1;
      rResp_d = RESP_OKAY;
      unique case (s_axi_araddr & ADDR_WORD_MASK)
        ADDR_CTRL: rData_d = {30'h0, ctrl_q};
        ADDR_STATUS: rData_d = statusWord;
        ADDR_TDELAY: rData_d = {16'h0, tDelay_q};
        default: begin
          rData_d = 32'h0;
          rResp_d = RESP_SLVERR;
        end
      endcase
    end
    awReady_d = !awGot_d && !bValid_d;
    wReady_d = !wGot_d && !bValid_d;
    arReady_d = !rValid_d;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET;
      tDelay_q <= TDELAY_RESET;
      awGot_q <= 1'b0;
      awAddr_q <= '0;
      wGot_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
      awReady_q <= 1'b1;
      wReady_q <= 1'b1;
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
      arReady_q <= 1'b1;
      rValid_q <= 1'b0;
      rData_q <= '0;
      rResp_q <= RESP_OKAY;
    end else begin
      ctrl_q <= ctrl_d;
      tDelay_q <= tDelay_d;
      awGot_q <= awGot_d;
      awAddr_q <= awAddr_d;
      wGot_q <= wGot_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      awReady_q <= awReady_d;
      wReady_q <= wReady_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      arReady_q <= arReady_d;
      rValid_q <= rValid_d;
      rData_q <= rData_d;
      rResp_q <= rResp_d;
    end
  end

  // ==========================================================================
  // Frame sequencer
  assign tick = pdiv_q == PDIV_LAST;
  assign trigLevel = pins.grabberTriggerIn & pins.coaxTriggerIn;
  assign trigRise = trigLevel && !trigPrev_q;
  assign extMode = pins.triggerSourceSelect;
  assign geomQ = geomOf(bin_q);
  assign pixLast = 11'(GUARD_PIX + geomQ.dumPix + geomQ.effPix
                       + geomQ.gapPix - 11'h001);
  assign lineLast = 11'(geomQ.dumLin + geomQ.effLin - 11'h001);

  always_comb begin
    state_d = state_q;
    bin_d = bin_q;
    pixCnt_d = pixCnt_q;
    lineCnt_d = lineCnt_q;
    delayCnt_d = delayCnt_q;
    frameCnt_d = frameCnt_q;
    trigPrev_d = trigLevel;
    pdiv_d = tick ? 2'h0 : 2'(pdiv_q + 2'h1);
    unique case (state_q)
      ST_IDLE: begin
        if (ctrl_q[CTRL_RUN] && tick) begin
          pixCnt_d = '0;
          lineCnt_d = '0;
          if (extMode) begin
            state_d = ST_WAIT;
          end else begin
            state_d = ST_SCAN;
            bin_d = binDecode({pins.binningSelectHigh,
                               pins.binningSelectLow});
          end
        end
      end
      ST_WAIT: begin
        if (!ctrl_q[CTRL_RUN] || !extMode) begin
          state_d = ST_IDLE;
        end else if (trigRise) begin
          state_d = ST_DELAY;
          delayCnt_d = tDelay_q;
        end
      end
      ST_DELAY: begin
        if (tick) begin
          if (delayCnt_q == 16'h0) begin
            state_d = ST_SCAN;
            bin_d = binDecode({pins.binningSelectHigh,
                               pins.binningSelectLow});
          end else begin
            delayCnt_d = 16'(delayCnt_q - 16'h1);
          end
        end
      end
      ST_SCAN: begin
        if (tick) begin
          if (pixCnt_q == pixLast) begin
            pixCnt_d = '0;
            if (lineCnt_q == lineLast) begin
              state_d = ST_IDLE;
              frameCnt_d = 16'(frameCnt_q + 16'h1);
            end else begin
              lineCnt_d = 11'(lineCnt_q + 11'h001);
            end
          end else begin
            pixCnt_d = 11'(pixCnt_q + 11'h001);
          end
        end
      end
    endcase
  end

  // ==========================================================================
  // Video port and column scan
  assign geomD = geomOf(bin_d);
  assign actStart = GUARD_PIX;
  assign effStart = 11'(GUARD_PIX + geomD.dumPix);
  assign gapStart = 11'(effStart + geomD.effPix);
  assign inLine = (state_d == ST_SCAN) && (pixCnt_d >= actStart)
                  && (pixCnt_d < gapStart);
  assign inEff = inLine && (pixCnt_d >= effStart)
                 && (lineCnt_d >= geomD.dumLin);
  assign colRaw = 11'((pixCnt_d - actStart) * geomD.step);
  assign col = (colRaw > COL_LAST) ? COL_LAST : colRaw;

  always_comb begin
    video_d.frameSync = state_d == ST_SCAN;
    video_d.lineSync = inLine;
    video_d.pixelClk = pdiv_d < PDIV_FALL;
    video_d.pixelWordLines = video_q.pixelWordLines;
    if (tick) begin
      video_d.pixelWordLines = '0;
      if (inEff) begin
        video_d.pixelWordLines = ctrl_q[CTRL_TEST] ? col[WORD_W-1:0]
                                                   : adcWord;
      end
    end
    videoN_d = ~video_d;
    scanActive_d = inLine;
    scanGroup_d = 3'(col / GROUP_CH);
    scanChan_d = 8'(col % GROUP_CH);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      bin_q <= BINNING_SELECT_HIGH;
      pdiv_q <= 2'(PDIV_FALL - 2'h1);
      pixCnt_q <= '0;
      lineCnt_q <= '0;
      delayCnt_q <= '0;
      frameCnt_q <= '0;
      trigPrev_q <= 1'b1;
      video_q <= '0;
      videoN_q <= '1;
      scanActive_q <= 1'b0;
      scanGroup_q <= '0;
      scanChan_q <= '0;
    end else begin
      state_q <= state_d;
      bin_q <= bin_d;
      pdiv_q <= pdiv_d;
      pixCnt_q <= pixCnt_d;
      lineCnt_q <= lineCnt_d;
      delayCnt_q <= delayCnt_d;
      frameCnt_q <= frameCnt_d;
      trigPrev_q <= trigPrev_d;
      video_q <= video_d;
      videoN_q <= videoN_d;
      scanActive_q <= scanActive_d;
      scanGroup_q <= scanGroup_d;
      scanChan_q <= scanChan_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign video = video_q;
  assign videoN = videoN_q;
  assign scanActive = scanActive_q;
  assign scanGroup = scanGroup_q;
  assign scanChan = scanChan_q;
  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
endmodule // xpvrt_top

/* design/xpvrt_pkg.sv */
// Constants, types and helpers for the panel video readout timing
// ==========================================================================
package xpvrt_pkg;
  // ========================================================================
  // Clocking
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PCLK_PERIOD_NS = 160;
  localparam int unsigned PCLK_DIV = PCLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] PDIV_LAST = 2'(PCLK_DIV - 1);
  localparam logic [1:0] PDIV_FALL = 2'(PCLK_DIV / 2);
  // ========================================================================
  // Geometry
  localparam int WORD_W = 12;
  localparam logic [10:0] GUARD_PIX = 11'h011;
  localparam logic [10:0] COL_LAST = 11'h41f;
  localparam logic [10:0] GROUP_CH = 11'h084;
  localparam logic [10:0] EFF_PIX1 = 11'h408;
  localparam logic [10:0] EFF_PIX2 = 11'h204;
  localparam logic [10:0] EFF_PIX4 = 11'h102;
  localparam logic [10:0] DUM_PIX1 = 11'h019;
  localparam logic [10:0] DUM_PIX2 = 11'h00d;
  localparam logic [10:0] DUM_PIX4 = 11'h007;
  localparam logic [10:0] GAP_PIX1 = 11'h16e;
  localparam logic [10:0] GAP_PIX2 = 11'h37e;
  localparam logic [10:0] GAP_PIX4 = 11'h486;
  localparam logic [10:0] EFF_LIN1 = 11'h3f4;
  localparam logic [10:0] EFF_LIN2 = 11'h1fa;
  localparam logic [10:0] EFF_LIN4 = 11'h0fd;
  localparam logic [10:0] DUM_LIN1 = 11'h02c;
  localparam logic [10:0] DUM_LIN2 = 11'h016;
  localparam logic [10:0] DUM_LIN4 = 11'h00b;
  // ========================================================================
  // Binning pin codes
  localparam logic [1:0] BINSEL_2X2 = 2'h1;
  localparam logic [1:0] BINSEL_4X4 = 2'h2;
  // ========================================================================
  // Register map
  localparam int AXI_AW = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_TDELAY = 4'h8;
  localparam logic [3:0] ADDR_WORD_MASK = 4'hc;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_TEST = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [15:0] TDELAY_RESET = 16'h0100;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ========================================================================
  // Types
  typedef enum logic [1:0] {
    BINNING_SELECT_HIGH = 2'h0,
    BIN2 = 2'h1,
    BIN4 = 2'h2
  } xpvrt_bin_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_DELAY = 4'h4,
    ST_SCAN = 4'h8
  } xpvrt_state_e;
  typedef struct packed {
    logic frameSync;
    logic lineSync;
    logic pixelClk;
    logic [WORD_W-1:0] pixelWordLines;
  } xpvrt_video_s;
  typedef struct packed {
    logic binningSelectLow;
    logic binningSelectHigh;
    logic grabberTriggerIn;
    logic coaxTriggerIn;
    logic triggerSourceSelect;
  } xpvrt_pins_s;
  typedef struct packed {
    logic [10:0] effPix;
    logic [10:0] dumPix;
    logic [10:0] gapPix;
    logic [10:0] effLin;
    logic [10:0] dumLin;
    logic [10:0] step;
  } xpvrt_geom_s;
  // ========================================================================
  // Helpers
  function automatic xpvrt_bin_e binDecode(input logic [1:0] pins);
    unique case (pins)
      BINSEL_2X2: binDecode = BIN2;
      BINSEL_4X4: binDecode = BIN4;
      default: binDecode = BINNING_SELECT_HIGH;
    endcase
  endfunction
  function automatic xpvrt_geom_s geomOf(input xpvrt_bin_e b);
    unique case (b)
      BIN2: geomOf = '{EFF_PIX2, DUM_PIX2, GAP_PIX2, EFF_LIN2, DUM_LIN2,
                       11'h002};
      BIN4: geomOf = '{EFF_PIX4, DUM_PIX4, GAP_PIX4, EFF_LIN4, DUM_LIN4,
                       11'h004};
      default: geomOf = '{EFF_PIX1, DUM_PIX1, GAP_PIX1, EFF_LIN1, DUM_LIN1,
                          11'h001};
    endcase
  endfunction
endpackage

/* design/xpvrt_sync.sv */
// Two-flop synchroniser bank for static pin levels
`timescale 1ns/1ps
module xpvrt_sync
  import xpvrt_pkg::*;
#(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] stage1_q;
  logic [W-1:0] stage1_d;
  logic [W-1:0] stage2_q;
  logic [W-1:0] stage2_d;

  always_comb begin
    stage1_d = asyncIn;
    stage2_d = stage1_q;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign syncOut = stage2_q;
endmodule // xpvrt_sync

/* sim/xpvrt_sva.sv */
// Concurrent checks on the video port of the readout timing block
`timescale 1ns/1ps
module xpvrt_sva
  import xpvrt_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input xpvrt_video_s video,
  input xpvrt_video_s videoN,
  input wire logic scanActive,
  input wire logic [2:0] scanGroup,
  input wire logic [7:0] scanChan
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ========================================================================
  // Video port
  AST_DIFF_PAIR: assert property (videoN == ~video)
    else $error("complement side differs from true side");
  AST_WORD_EDGE: assert property ($changed(video.pixelWordLines) |->
    $rose(video.pixelClk))
    else $error("word changed off the pixel clock rise");
  AST_WORD_ZERO: assert property (!video.lineSync |->
    video.pixelWordLines == 12'h000)
    else $error("word nonzero outside line sync");
  AST_LINE_IN_FRAME: assert property (video.lineSync |->
    video.frameSync)
    else $error("line sync outside frame sync");
  AST_LINE_EDGE: assert property ($changed(video.lineSync) |->
    $rose(video.pixelClk))
    else $error("line sync moved off the pixel clock rise");
  AST_PCLK_SHAPE: assert property ($rose(video.pixelClk) |=>
    video.pixelClk ##1 !video.pixelClk)
    else $error("pixel clock high phase wrong");
  AST_GUARD: assert property ($rose(video.frameSync) |->
    ##68 $rose(video.lineSync))
    else $error("guard interval length wrong");
  // ========================================================================
  // Column scan
  AST_SCAN_MATCH: assert property (scanActive == video.lineSync)
    else $error("scan active differs from line sync");
  AST_COLUMN_RANGE: assert property (scanActive |-> scanChan <= 8'h83)
    else $error("channel index beyond group size");
  AST_SCAN_FIRST: assert property ($rose(scanActive) |->
    scanGroup == 3'h0 && scanChan == 8'h00)
    else $error("column scan does not start at column zero");
  AST_SCAN_LAST: assert property ($fell(scanActive) |->
    $past(scanGroup) == 3'h7 && $past(scanChan) == 8'h83)
    else $error("column scan does not end at the last column");
endmodule // xpvrt_sva

bind xpvrt_top xpvrt_sva i_xpvrt_sva (
  .clk(clk), .nrst(nrst), .video(video), .videoN(videoN),
  .scanActive(scanActive), .scanGroup(scanGroup), .scanChan(scanChan)
);

/* sim/xpvrt_grabber.sv */
// Frame grabber model measuring the parallel video timing
`timescale 1ns/1ps
module xpvrt_grabber
  import xpvrt_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input xpvrt_video_s video,
  output logic [10:0] loCnt,
  output logic [10:0] hiCnt,
  output logic [10:0] nzLine,
  output logic [10:0] lineCnt
);
  logic pclkQ, lsQ, fsQ, smp, nzWord;
  logic [10:0] runCnt, nzCnt;
  assign smp = pclkQ && !video.pixelClk;
  assign nzWord = video.pixelWordLines != 12'h000;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {pclkQ, lsQ, fsQ} <= 3'h0;
      {runCnt, nzCnt, loCnt, hiCnt, nzLine, lineCnt} <= '0;
    end else begin
      pclkQ <= video.pixelClk;
      if (smp) begin
        fsQ <= video.frameSync;
        lsQ <= video.lineSync;
        runCnt <= runCnt + 11'h001;
        if (video.lineSync && nzWord) nzCnt <= nzCnt + 11'h001;
        if (video.frameSync && !fsQ) begin
          runCnt <= 11'h001;
          lineCnt <= 11'h000;
        end
        if (video.lineSync && !lsQ) begin
          loCnt <= runCnt;
          runCnt <= 11'h001;
          lineCnt <= lineCnt + 11'h001;
          nzCnt <= {10'h000, nzWord};
        end
        if (!video.lineSync && lsQ) begin
          hiCnt <= runCnt;
          nzLine <= nzCnt;
          runCnt <= 11'h001;
        end
      end
    end
  end
endmodule // xpvrt_grabber

/* sim/xpvrt_top_tb.sv */
// Self-checking testbench for the panel video readout timing block
`timescale 1ns/1ps
module xpvrt_top_tb
  import xpvrt_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic binningSelectLow = 1'b0;
  logic binningSelectHigh = 1'b0;
  logic grabberTriggerIn = 1'b1;
  logic coaxTriggerIn = 1'b1;
  logic triggerSourceSelect = 1'b1;
  logic [WORD_W-1:0] adcWord = 12'h5a1;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, scanActive;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0] scanGroup;
  logic [7:0] scanChan;
  logic [10:0] loCnt, hiCnt, nzLine, lineCnt;
  xpvrt_video_s video, videoN;
  int errorCnt = 0;
  int compares = 0;
  logic [10:0] hiExp [4] = '{11'h421, 11'h211, 11'h109, 11'h421};
  logic [10:0] loExp [4] = '{11'h17f, 11'h38f, 11'h497, 11'h17f};
  logic [31:0] binExp [4] = '{32'h0, 32'h1, 32'h2, 32'h0};

  xpvrt_top i_xpvrt_top (
    .clk(clk), .nrst(nrst), .binningSelectLow(binningSelectLow),
    .binningSelectHigh(binningSelectHigh), .adcWord(adcWord),
    .grabberTriggerIn(grabberTriggerIn), .coaxTriggerIn(coaxTriggerIn),
    .triggerSourceSelect(triggerSourceSelect), .video(video),
    .videoN(videoN), .scanActive(scanActive), .scanGroup(scanGroup),
    .scanChan(scanChan), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  xpvrt_grabber i_xpvrt_grabber (
    .clk(clk), .nrst(nrst), .video(video), .loCnt(loCnt),
    .hiCnt(hiCnt), .nzLine(nzLine), .lineCnt(lineCnt)
  );

  always #20 clk = ~clk;
  always @(posedge clk) adcWord <= adcWord + 12'h001;

  // ========================================================================
  // Tasks
  task automatic endSim();
    if (errorCnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic doReset(input logic [1:0] code);
    nrst <= 1'b0;
    triggerSourceSelect <= 1'b1;
    {binningSelectHigh, binningSelectLow} <= code;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d,
                       output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk(32'(n), 32'h3);
  endtask
  task automatic axiRd(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, RESP_OKAY});
    s_axi_rready <= 1'b0;
    chk(32'(n), 32'h2);
  endtask
  task automatic waitLines(input logic [10:0] n);
    int i;
    for (i = 0; i < 7000 && lineCnt !== n; i++) @(posedge clk);
    chk({21'h0, lineCnt}, {21'h0, n});
  endtask

  // ========================================================================
  // Tests
  initial begin
    logic [31:0] rd;
    logic [1:0] rs;
    int n;
    repeat (2) @(posedge clk);
    chk({17'h0, videoN}, 32'h7fff);
    doReset(2'h0);
    axiRd(ADDR_CTRL, rd);
    chk(rd & 32'h3, 32'h1);
    axiRd(ADDR_TDELAY, rd);
    chk(rd, 32'h100);
    axiWr(ADDR_STATUS, 32'hffffffff, rs);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    axiWr(4'hc, 32'h0, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    for (int c = 0; c < 4; c++) begin
      doReset(2'(c));
      triggerSourceSelect <= 1'b0;
      waitLines(11'h001);
      chk({21'h0, loCnt}, 32'h11);
      {binningSelectHigh, binningSelectLow} <= ~2'(c);
      axiRd(ADDR_STATUS, rd);
      chk({30'h0, rd[4:3]}, binExp[c]);
      waitLines(11'h002);
      chk({21'h0, hiCnt}, {21'h0, hiExp[c]});
      chk({21'h0, loCnt}, {21'h0, loExp[c]});
      chk({21'h0, nzLine}, 32'h0);
      if (c == 2) begin
        axiWr(ADDR_CTRL, 32'h3, rs);
        chk({30'h0, rs}, {30'h0, RESP_OKAY});
        for (int l = 3; l < 14; l++) waitLines(11'(l));
        chk({21'h0, nzLine}, {21'h0, EFF_PIX4});
      end
    end
    for (int s = 0; s < 2; s++) begin
      doReset(2'h0);
      axiWr(ADDR_TDELAY, 32'h2, rs);
      chk({30'h0, rs}, {30'h0, RESP_OKAY});
      axiRd(ADDR_TDELAY, rd);
      chk(rd, 32'h2);
      axiRd(ADDR_STATUS, rd);
      chk(rd & 32'h22, 32'h22);
      repeat (40) @(posedge clk);
      chk({31'h0, video.frameSync}, 32'h0);
      if (s == 0) grabberTriggerIn <= 1'b0;
      else coaxTriggerIn <= 1'b0;
      repeat (4) @(posedge clk);
      grabberTriggerIn <= 1'b1;
      coaxTriggerIn <= 1'b1;
      for (n = 0; n < 100 && video.frameSync !== 1'b1; n++) @(posedge clk);
      chk({31'h0, n >= 12 && n <= 28}, 32'h1);
    end
    endSim();
  end

  initial begin
    #3800000;
    errorCnt++;
    endSim();
  end
endmodule // xpvrt_top_tb
